// >>> rtl/sfp_top.sv
// serial flash command check, write protection and secured area control
// Summary of operation
// - power-up reset puts command logic in standby
// - act only on whole bytes ending on boundary
// - data changes need write enable latch set
// - deep power-down ignores writes, wakes at end of next frame
// - change array only after complete valid sequence
// - any nonzero protect level locks whole block
// - top/bottom bit never changes protection outcome
// - protect pin guards protect and disable bits
// - four-line mode disables hardware protected mode
// - chip erase only when protect field zero
// - protect pin doubles as data line two
// - pause pin holds link, doubles data three
// - secured area is two 4K-bit rows
// - customer half low, factory half high
// - security bit zero shows factory lock
// - lock command sets customer lock bit one
// - secured mode routes programming to secured area
// - locked secured half never changes again
// - secured mode forbids main array access
`include "sfp_cfg.svh"
`timescale 1ns/1ps
module sfp_top (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    // serial link pins
    input  wire logic                   sclk,
    input  wire logic                   cs_n,
    input  wire logic                   data0_in,
    input  wire logic                   write_protect_n_or_data2_in,
    output logic                        write_protect_n_or_data2_out,
    output logic                        write_protect_n_or_data2_oe_n,
    input  wire logic                   pause_n_or_data3_in,
    output logic                        pause_n_or_data3_out,
    output logic                        pause_n_or_data3_oe_n,
    // configuration, fuses and array busy
    input  wire logic                   quad_enable,
    input  wire logic                   factory_lock_fuse,
    input  wire logic                   customer_lock_fuse,
    input  wire logic                   array_busy,
    // operation request to the array
    output logic                        op_valid,
    output sfp_pkg::sfp_op_type         op,
    input  wire logic [7:0]             page_rd_index,
    output logic [7:0]                  page_rd_data,
    // status
    output sfp_pkg::sfp_status_type     status,
    output logic [1:0]                  security_reg,
    output logic                        secured_mode,
    output logic                        deep_power_down,
    output logic                        software_protected_mode,
    output logic                        hardware_protected_mode
);
    logic [4:0]              lvl;
    logic                    s_sclk;
    logic                    s_cs_n;
    logic                    s_io0;
    logic                    s_wp_n;
    logic                    s_pause_n;
    logic                    sclk_q;
    logic                    cs_q;
    logic                    paused;
    sfp_pkg::sfp_state_type  state;
    logic [7:0]              shreg;
    logic [2:0]              bitcnt;
    logic [9:0]              bytecnt;
    logic [7:0]              opcode;
    logic [23:0]             addr;
    logic [7:0]              wr_status;
    logic [8:0]              datacnt;
    logic [7:0]              page_buf [0:255];
    logic                    customer_lock;
    logic                    sclk_rise;
    logic                    cs_fall;
    logic                    cs_rise;
    logic                    byte_done;
    logic [7:0]              next_byte;
    logic                    frame_end;
    logic                    len_ok;
    logic                    accept;
    logic                    protect;

    function automatic logic is_write_op(input logic [7:0] code);
        is_write_op = (code == `SFP_CMD_WRSR_CODE) || (code == `SFP_CMD_PP_CODE) ||
                      (code == `SFP_CMD_SE_CODE) || (code == `SFP_CMD_CE_CODE) ||
                      (code == `SFP_CMD_LOCK_CODE);
    endfunction : is_write_op

    // upper address bit of the secured window picks the half
    function automatic logic half_locked(input logic [23:0] a, input logic fl, input logic cl);
        half_locked = a[`SFP_OTP_HALF_POS] ? fl : cl;
    endfunction : half_locked

    sfp_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin     ({sclk, cs_n, data0_in, write_protect_n_or_data2_in, pause_n_or_data3_in}),
        .level   (lvl)
    );
    assign {s_sclk, s_cs_n, s_io0, s_wp_n, s_pause_n} = lvl;

    // never drives the shared pins: read paths live elsewhere
    assign write_protect_n_or_data2_out  = 1'b0;
    assign write_protect_n_or_data2_oe_n = 1'b1;
    assign pause_n_or_data3_out          = 1'b0;
    assign pause_n_or_data3_oe_n         = 1'b1;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            // matches the synchroniser's reset level, so no false edge follows reset
            sclk_q <= 1'b1;
            cs_q   <= 1'b1;
        end else begin
            sclk_q <= s_sclk;
            cs_q   <= s_cs_n;
        end
    end

    assign sclk_rise = s_sclk & ~sclk_q & ~s_cs_n & ~paused;
    assign cs_fall   = cs_q & ~s_cs_n;
    assign cs_rise   = ~cs_q & s_cs_n;

    // pause only starts or ends while the clock is low, also ends on deselect; off in four-line mode
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            paused <= 1'b0;
        end else if (quad_enable || s_cs_n) begin
            paused <= 1'b0;
        end else if (!s_sclk) begin
            paused <= ~s_pause_n;
        end
    end

    assign byte_done = (state == sfp_pkg::SFP_ST_ACTIVE) && sclk_rise && (bitcnt == 3'h7);
    assign next_byte = {shreg[6:0], s_io0};
    assign frame_end = (state == sfp_pkg::SFP_ST_ACTIVE) && cs_rise;

    // standby after power-up; busy array turns the whole frame away
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= sfp_pkg::SFP_ST_IDLE;
        end else begin
            unique case (state)
                sfp_pkg::SFP_ST_IDLE: begin
                    if (cs_fall) begin
                        state <= array_busy ? sfp_pkg::SFP_ST_DISCARD : sfp_pkg::SFP_ST_ACTIVE;
                    end
                end
                sfp_pkg::SFP_ST_ACTIVE: begin
                    if (cs_rise) begin
                        state <= (accept && opcode == `SFP_CMD_DPD_CODE) ?
                                 sfp_pkg::SFP_ST_SLEEP : sfp_pkg::SFP_ST_IDLE;
                    end
                end
                sfp_pkg::SFP_ST_DISCARD: begin
                    if (cs_rise) begin
                        state <= sfp_pkg::SFP_ST_IDLE;
                    end
                end
                sfp_pkg::SFP_ST_SLEEP: begin
                    if (cs_rise) begin
                        state <= sfp_pkg::SFP_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // serial shift, single-line command phase
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            shreg   <= 8'h00;
            bitcnt  <= 3'h0;
            bytecnt <= 10'h000;
        end else if (cs_fall) begin
            bitcnt  <= 3'h0;
            bytecnt <= 10'h000;
        end else if (state == sfp_pkg::SFP_ST_ACTIVE && sclk_rise) begin
            shreg  <= next_byte;
            bitcnt <= bitcnt + 3'h1;
            if (byte_done && bytecnt != 10'h3FF) begin
                bytecnt <= bytecnt + 10'h001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            opcode    <= 8'h00;
            addr      <= 24'h00_0000;
            wr_status <= 8'h00;
            datacnt   <= 9'h000;
        end else if (cs_fall) begin
            datacnt <= 9'h000;
        end else if (byte_done) begin
            unique case (bytecnt)
                10'h000: opcode <= next_byte;
                10'h001: begin
                    addr[23:16] <= next_byte;
                    wr_status   <= next_byte;
                end
                10'h002: addr[15:8] <= next_byte;
                10'h003: addr[7:0]  <= next_byte;
                default: begin
                    if (datacnt != `SFP_DATA_MAX) begin
                        datacnt <= datacnt + 9'h001;
                    end
                end
            endcase
        end
    end

    // data bytes are only buffered; nothing reaches the array before the frame closes
    always_ff @(posedge clk_sys) begin
        if (byte_done && bytecnt >= 10'h004) begin
            page_buf[addr[7:0] + datacnt[7:0]] <= next_byte;
        end
        page_rd_data <= page_buf[page_rd_index];
    end

    assign protect = |status.block_protect_field;
    assign software_protected_mode = protect;
    // the protect pin is a data line in four-line mode
    assign hardware_protected_mode = status.status_write_disable_bit &
                                     ~quad_enable & ~s_wp_n;

    always_comb begin
        unique case (opcode)
            `SFP_CMD_WRSR_CODE: len_ok = (bytecnt == `SFP_LEN_STATUS);
            `SFP_CMD_SE_CODE:   len_ok = (bytecnt == `SFP_LEN_ERASE);
            `SFP_CMD_PP_CODE:   len_ok = (bytecnt >= `SFP_LEN_PROG_MIN);
            default:            len_ok = (bytecnt == `SFP_LEN_SHORT);
        endcase
        accept = (bitcnt == 3'h0) && len_ok && (!is_write_op(opcode) ||
                 status.write_enable_latch);
        unique case (opcode)
            `SFP_CMD_PP_CODE:   accept = accept && (secured_mode ?
                                !half_locked(addr, factory_lock_fuse, customer_lock) :
                                !protect);
            `SFP_CMD_SE_CODE:   accept = accept && !secured_mode && !protect;
            `SFP_CMD_CE_CODE:   accept = accept && !secured_mode &&
                                (status.block_protect_field == 4'h0);
            `SFP_CMD_WRSR_CODE: accept = accept && !hardware_protected_mode;
            default:            accept = accept;
        endcase
    end

    // status byte and write enable latch
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status.write_enable_latch       <= 1'b0;
            status.block_protect_field      <= `SFP_RST_BP;
            status.status_write_disable_bit <= `SFP_RST_STATUS_WRITE_DISABLE_BIT;
            status.top_bottom_select_bit    <= `SFP_RST_TB;
        end else if (frame_end && accept) begin
            if (opcode == `SFP_CMD_WRITE_ENABLE_CMD_CODE) begin
                status.write_enable_latch <= 1'b1;
            end else if (opcode == `SFP_CMD_WRDI_CODE || is_write_op(opcode)) begin
                status.write_enable_latch <= 1'b0;
            end
            if (opcode == `SFP_CMD_WRSR_CODE) begin
                status.block_protect_field      <= wr_status[`SFP_SR_BP_HI:`SFP_SR_BP_LO];
                status.status_write_disable_bit <= wr_status[`SFP_SR_STATUS_WRITE_DISABLE_BIT_POS];
                status.top_bottom_select_bit    <= wr_status[`SFP_SR_TB_POS];
            end
        end
    end

    // secured mode and customer lock; the lock fuse is permanent storage
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            secured_mode  <= 1'b0;
            customer_lock <= 1'b0;
        end else begin
            if (frame_end && accept && opcode == `SFP_CMD_ENTER_CODE) begin
                secured_mode <= 1'b1;
            end else if (frame_end && accept && opcode == `SFP_CMD_EXIT_CODE) begin
                secured_mode <= 1'b0;
            end
            if (customer_lock_fuse || (frame_end && accept && opcode == `SFP_CMD_LOCK_CODE)) begin
                customer_lock <= 1'b1;
            end
        end
    end

    assign security_reg    = {customer_lock, factory_lock_fuse};
    assign deep_power_down = (state == sfp_pkg::SFP_ST_SLEEP);

    // array requests, one pulse per accepted program, erase or lock frame
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            op_valid <= 1'b0;
            op       <= '0;
        end else begin
            op_valid <= 1'b0;
            if (frame_end && accept && is_write_op(opcode) &&
                opcode != `SFP_CMD_WRSR_CODE) begin
                op_valid  <= 1'b1;
                op.to_otp <= secured_mode;
                op.addr   <= addr;
                op.count  <= datacnt;
                unique case (opcode)
                    `SFP_CMD_PP_CODE: op.kind <= sfp_pkg::SFP_OP_PROGRAM;
                    `SFP_CMD_SE_CODE: op.kind <= sfp_pkg::SFP_OP_SECTOR;
                    `SFP_CMD_CE_CODE: op.kind <= sfp_pkg::SFP_OP_CHIP;
                    default:          op.kind <= sfp_pkg::SFP_OP_LOCK;
                endcase
            end
        end
    end

    sequence s_frame_end;
        frame_end;
    endsequence

    sequence s_bad_frame;
        frame_end && (bitcnt != 3'h0);
    endsequence

    chk_op_after_frame: assert property (@(posedge clk_sys) disable iff (!rst_b)
        op_valid |-> $past(frame_end))
        else $error("operation issued without a closed frame");

    chk_whole_bytes: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_bad_frame |=> !op_valid && $stable(status) && $stable(secured_mode))
        else $error("partial byte frame acted on");

    chk_latch_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_frame_end ##0 (is_write_op(opcode) && !status.write_enable_latch)
        |=> !op_valid && $stable(status.block_protect_field))
        else $error("write accepted without write enable latch");

    chk_sleep_ignore: assert property (@(posedge clk_sys) disable iff (!rst_b)
        deep_power_down |=> !op_valid && $stable(status) && $stable(security_reg))
        else $error("write acted on in deep power-down");

    chk_block_protect: assert property (@(posedge clk_sys) disable iff (!rst_b)
        op_valid && !op.to_otp && op.kind != sfp_pkg::SFP_OP_LOCK
        |-> status.block_protect_field == 4'h0)
        else $error("protected block changed");

    chk_chip_erase: assert property (@(posedge clk_sys) disable iff (!rst_b)
        op_valid && op.kind == sfp_pkg::SFP_OP_CHIP
        |-> status.block_protect_field == 4'h0 && !op.to_otp)
        else $error("chip erase with protect bits set");

    chk_pin_guard: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_frame_end ##0 (opcode == `SFP_CMD_WRSR_CODE && hardware_protected_mode)
        |=> $stable(status.block_protect_field) && $stable(status.status_write_disable_bit))
        else $error("protect bits changed under pin protection");

    chk_quad_no_pin: assert property (@(posedge clk_sys) disable iff (!rst_b)
        quad_enable |-> !hardware_protected_mode ##1 !paused)
        else $error("pin protection active in four-line mode");

    chk_otp_route: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_frame_end ##0 secured_mode) ##1 op_valid
        |-> op.to_otp && op.kind inside {sfp_pkg::SFP_OP_PROGRAM, sfp_pkg::SFP_OP_LOCK})
        else $error("secured mode reached the main array");

    chk_otp_locked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        op_valid && op.to_otp && op.kind == sfp_pkg::SFP_OP_PROGRAM
        |-> !half_locked(op.addr, $past(factory_lock_fuse), $past(customer_lock)))
        else $error("locked secured half programmed");

    chk_cust_lock: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_frame_end ##0 (accept && opcode == `SFP_CMD_LOCK_CODE) |=> ##[0:2] security_reg[1])
        else $error("customer lock bit not set");
endmodule : sfp_top

// >>> rtl/sfp_cfg.svh
// constants of the serial flash protection block
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH
// command codes
`define SFP_CMD_WRITE_ENABLE_CMD_CODE    8'h06
`define SFP_CMD_WRDI_CODE    8'h04
`define SFP_CMD_WRSR_CODE    8'h01
`define SFP_CMD_PP_CODE      8'h02
`define SFP_CMD_SE_CODE      8'h20
`define SFP_CMD_CE_CODE      8'h60
`define SFP_CMD_DPD_CODE     8'hB9
`define SFP_CMD_ENTER_CODE   8'hB1
`define SFP_CMD_EXIT_CODE    8'hC1
`define SFP_CMD_LOCK_CODE    8'h2F
// frame lengths in bytes
`define SFP_LEN_SHORT        10'h001
`define SFP_LEN_STATUS       10'h002
`define SFP_LEN_ERASE        10'h004
`define SFP_LEN_PROG_MIN     10'h005
`define SFP_DATA_MAX         9'h100
// status byte field positions
`define SFP_SR_STATUS_WRITE_DISABLE_BIT_POS      7
`define SFP_SR_TB_POS        6
`define SFP_SR_BP_HI         5
`define SFP_SR_BP_LO         2
// secured area: 1K bytes, two 4096-bit halves
`define SFP_OTP_CUST_BASE    10'h000
`define SFP_OTP_CUST_LAST    10'h1FF
`define SFP_OTP_FACT_BASE    10'h200
`define SFP_OTP_FACT_LAST    10'h3FF
`define SFP_OTP_HALF_POS     9
// reset values
`define SFP_RST_BP           4'h0
`define SFP_RST_STATUS_WRITE_DISABLE_BIT         1'b0
`define SFP_RST_TB           1'b0
`endif

// >>> rtl/sfp_pkg.sv
// types of the serial flash protection block
package sfp_pkg;
    typedef enum logic [1:0] {
        SFP_OP_PROGRAM = 2'h0,
        SFP_OP_SECTOR  = 2'h1,
        SFP_OP_CHIP    = 2'h2,
        SFP_OP_LOCK    = 2'h3
    } sfp_op_kind_type;

    typedef struct packed {
        sfp_op_kind_type kind;
        logic            to_otp;
        logic [23:0]     addr;
        logic [8:0]      count;
    } sfp_op_type;

    typedef struct packed {
        logic       status_write_disable_bit;
        logic       top_bottom_select_bit;
        logic [3:0] block_protect_field;
        logic       write_enable_latch;
    } sfp_status_type;

    typedef enum logic [3:0] {
        SFP_ST_IDLE    = 4'h1,
        SFP_ST_ACTIVE  = 4'h2,
        SFP_ST_DISCARD = 4'h4,
        SFP_ST_SLEEP   = 4'h8
    } sfp_state_type;
endpackage : sfp_pkg

// >>> rtl/sfp_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module sfp_sync #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // pins and synchronised levels
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    stage[i] <= 1'b1;
                    level[i] <= 1'b1;
                end else begin
                    stage[i] <= pin[i];
                    level[i] <= stage[i];
                end
            end
        end
    endgenerate
endmodule : sfp_sync

// >>> testbench/sfp_host_model.sv
// behavioural serial host that drives command frames into the flash block
`timescale 1ns/1ps
module sfp_host_model (
    // serial link
    output logic sclk,
    output logic cs_n,
    output logic data0
);
    initial begin
        sclk  = 1'b0;
        cs_n  = 1'b1;
        data0 = 1'b0;
    end

    // clock stands low between frames, half period 80 ns, odd offset keeps it unrelated
    task automatic start();
        #3.3 cs_n = 1'b0;
        #80;
    endtask : start

    task automatic bit_out(input logic b);
        data0 = b;
        #80 sclk = 1'b1;
        #80 sclk = 1'b0;
    endtask : bit_out

    task automatic byte_out(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bit_out(b[i]);
        end
    endtask : byte_out

    // released line shows the inverse so a stale bit can never pass as data
    task automatic stop();
        #80 cs_n = 1'b1;
        data0 = ~data0;
        #400;
    endtask : stop
endmodule : sfp_host_model

// >>> testbench/sfp_top_test.sv
// self-checking bench for the flash protection and secured area block
`timescale 1ns/1ps
`include "sfp_cfg.svh"
module sfp_top_test;
    logic                    clk_sys;
    logic                    rst_b;
    logic                    sclk;
    logic                    cs_n;
    logic                    data0;
    logic                    write_protect_n_or_data2;
    logic                    pause_n_or_data3;
    logic                    quad_enable;
    logic                    factory_lock_fuse;
    logic                    customer_lock_fuse;
    logic                    array_busy;
    logic                    op_valid;
    sfp_pkg::sfp_op_type     op;
    sfp_pkg::sfp_op_type     last_op;
    logic [7:0]              page_rd_index;
    logic [7:0]              page_rd_data;
    sfp_pkg::sfp_status_type status;
    logic [1:0]              security_reg;
    logic                    secured_mode;
    logic                    deep_power_down;
    logic                    software_protected_mode;
    logic                    hardware_protected_mode;
    logic                    wp_oe_n;
    int                      fail_count = 0;
    int                      n_tests = 0;
    int                      n_ops = 0;
    int                      cycles = 0;
    int                      base;

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    sfp_host_model host_u (.sclk(sclk), .cs_n(cs_n), .data0(data0));

    sfp_top dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .data0_in(data0),
        .write_protect_n_or_data2_in(write_protect_n_or_data2),
        .write_protect_n_or_data2_out(), .write_protect_n_or_data2_oe_n(wp_oe_n),
        .pause_n_or_data3_in(pause_n_or_data3), .pause_n_or_data3_out(),
        .pause_n_or_data3_oe_n(), .quad_enable(quad_enable),
        .factory_lock_fuse(factory_lock_fuse), .customer_lock_fuse(customer_lock_fuse),
        .array_busy(array_busy), .op_valid(op_valid), .op(op),
        .page_rd_index(page_rd_index), .page_rd_data(page_rd_data), .status(status),
        .security_reg(security_reg), .secured_mode(secured_mode),
        .deep_power_down(deep_power_down), .software_protected_mode(software_protected_mode),
        .hardware_protected_mode(hardware_protected_mode)
    );

    // op_valid stands one cycle, so it is caught at every edge
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (op_valid === 1'b1) begin
            n_ops   <= n_ops + 1;
            last_op <= op;
        end
    end

    task automatic results();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    initial begin
        wait (cycles >= 90000);
        fail_count++;
        results();
    end

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] code);
        host_u.start();
        host_u.byte_out(code);
        host_u.stop();
    endtask : cmd

    task automatic acmd(input logic [7:0] code, input logic [23:0] a, input logic [7:0] d);
        host_u.start();
        host_u.byte_out(code);
        for (int i = 2; i >= 0; i--) begin
            host_u.byte_out(a[8*i +: 8]);
        end
        if (code == `SFP_CMD_PP_CODE) begin
            host_u.byte_out(d);
        end
        host_u.stop();
    endtask : acmd

    task automatic wrsr(input logic [7:0] v);
        cmd(`SFP_CMD_WRITE_ENABLE_CMD_CODE);
        host_u.start();
        host_u.byte_out(`SFP_CMD_WRSR_CODE);
        host_u.byte_out(v);
        host_u.stop();
    endtask : wrsr

    task automatic pins(input logic wp, input logic quad, input logic fuse);
        @(negedge clk_sys);
        write_protect_n_or_data2 = wp;
        quad_enable = quad;
        factory_lock_fuse = fuse;
        repeat (4) @(negedge clk_sys);
    endtask : pins

    initial begin
        rst_b = 1'b0;
        write_protect_n_or_data2 = 1'b1;
        pause_n_or_data3 = 1'b1;
        quad_enable = 1'b0;
        factory_lock_fuse = 1'b0;
        customer_lock_fuse = 1'b0;
        array_busy = 1'b0;
        page_rd_index = 8'h00;
        repeat (4) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("status", status, 64'h0);
        chk("modes", {secured_mode, deep_power_down, security_reg}, 64'h0);
        @(negedge clk_sys);
        array_busy = 1'b1;
        cmd(`SFP_CMD_WRITE_ENABLE_CMD_CODE);
        chk("busy", status, 64'h0);
        @(negedge clk_sys);
        array_busy = 1'b0;
        acmd(`SFP_CMD_SE_CODE, 24'h00_1000, 8'h00);
        chk("ops", n_ops, 64'h0);
        host_u.start();
        host_u.byte_out(`SFP_CMD_WRITE_ENABLE_CMD_CODE);
        host_u.bit_out(1'b0);
        host_u.stop();
        chk("latch", status, 64'h0);
        // a bit clocked while paused must not count, so the frame stays whole
        host_u.start();
        host_u.byte_out(`SFP_CMD_WRITE_ENABLE_CMD_CODE);
        @(negedge clk_sys);
        pause_n_or_data3 = 1'b0;
        host_u.bit_out(1'b1);
        @(negedge clk_sys);
        pause_n_or_data3 = 1'b1;
        host_u.stop();
        chk("pause", status, 64'h1);
        cmd(`SFP_CMD_WRITE_ENABLE_CMD_CODE);
        chk("latch", status, 64'h1);
        acmd(`SFP_CMD_SE_CODE, 24'h00_1000, 8'h00);
        chk("ops", n_ops, 64'h1);
        chk("addr", {last_op.kind, last_op.addr}, {sfp_pkg::SFP_OP_SECTOR, 24'h00_1000});
        chk("latch", status, 64'h0);
        // alternating the top/bottom bit across levels shows it never changes the outcome
        for (int lv = 0; lv < 16; lv++) begin
            wrsr({1'b0, lv[0], lv[3:0], 2'b00});
            chk("status", status, {1'b0, lv[0], lv[3:0], 1'b0});
            chk("soft", software_protected_mode, lv != 0);
            base = n_ops;
            cmd(`SFP_CMD_WRITE_ENABLE_CMD_CODE);
            cmd(`SFP_CMD_CE_CODE);
            acmd(`SFP_CMD_SE_CODE, 24'h00_0000, 8'h00);
            chk("erase", n_ops - base, lv == 0);
        end
        wrsr(8'h80);
        pins(1'b0, 1'b0, 1'b0);
        chk("hard", hardware_protected_mode, 64'h1);
        wrsr(8'h04);
        chk("status", status, 64'h41);
        pins(1'b0, 1'b1, 1'b0);
        chk("hard", {hardware_protected_mode, wp_oe_n}, 64'h1);
        wrsr(8'h00);
        chk("status", status, 64'h0);
        pins(1'b1, 1'b0, 1'b1);
        cmd(`SFP_CMD_DPD_CODE);
        chk("sleep", deep_power_down, 64'h1);
        cmd(`SFP_CMD_WRITE_ENABLE_CMD_CODE);
        chk("wake", {deep_power_down, status}, 64'h0);
        chk("sec", security_reg, 64'h1);
        cmd(`SFP_CMD_ENTER_CODE);
        chk("mode", secured_mode, 64'h1);
        base = n_ops;
        cmd(`SFP_CMD_WRITE_ENABLE_CMD_CODE);
        acmd(`SFP_CMD_SE_CODE, 24'h00_0000, 8'h00);
        acmd(`SFP_CMD_PP_CODE, 24'h00_0210, 8'hA5);
        chk("ops", n_ops - base, 64'h0);
        acmd(`SFP_CMD_PP_CODE, 24'h00_0010, 8'h5A);
        chk("otp", {last_op.kind, last_op.to_otp, last_op.addr[9:0]}, 64'h0410);
        chk("ops", n_ops - base, 64'h1);
        @(negedge clk_sys);
        page_rd_index = 8'h10;
        repeat (2) @(negedge clk_sys);
        chk("page", page_rd_data, 64'h5A);
        cmd(`SFP_CMD_WRITE_ENABLE_CMD_CODE);
        cmd(`SFP_CMD_LOCK_CODE);
        chk("lock", {last_op.kind, security_reg}, 64'hF);
        cmd(`SFP_CMD_WRITE_ENABLE_CMD_CODE);
        acmd(`SFP_CMD_PP_CODE, 24'h00_0020, 8'h33);
        chk("ops", n_ops - base, 64'h2);
        cmd(`SFP_CMD_EXIT_CODE);
        chk("mode", secured_mode, 64'h0);
        results();
    end
endmodule : sfp_top_test
